// File: core/fdcs_status_core.sv
// Purpose: status, interrupt and timer setup part of a floppy command engine
// Assumes: AHB-Lite slave, zero wait states; read/write engine sits outside
// Notes: drive pins pass two flops; engine ports share this clock
//
// Notes on behaviour
// - interrupt on entering result phase of read, write, scan, format commands.
// - interrupt on any ready level change and at seek or recalibrate end.
// - in programmed-I/O mode interrupt requests each execution-phase data transfer.
// - sense-interrupt clears interrupt, returns termination byte with cause in top bits.
// - cause bits 5,6,7: ready 0,1,1; seek normal 1,0,0; abnormal 1,1,0.
// - unsensed seek interrupt makes the next other command invalid.
// - head unload delay after read/write execution, 16 ms per count.
// - step spacing 1 to 16 ms, inverse code, F is 1 ms.
// - head settle delay before read/write, 2 ms per count up to 254 ms; the 8-bit settle code here reaches 510 ms.
// - all intervals from device clock; doubled in 4 MHz mode.
// - specify transfer-mode bit one selects programmed-I/O, zero selects DMA.
// - sense-drive returns fault, protect, ready, track zero, two-side, head, unit.
// - undefined command: no interrupt, result phase, termination byte 80H.
// - termination bits 7:6: normal, abnormal, invalid, ready changed.
// - seek end bit on positioning end; equipment check on fault or 77 steps.
// - not-ready bit for access to not-ready drive or side 1 single-sided.
// - termination byte carries head in bit 2 and unit in bits 1:0.
// - transfer error byte: end of cylinder 7, CRC 5, overrun 4; 6,3 zero.
// - transfer error byte: no data 2, write protect 1, missing mark 0.
// - data-field byte: 7 zero, deleted 6, CRC 5, missing mark 0 plus byte one.
// - data-field byte: wrong cylinder 4, bad cylinder 1, scan hit 3, miss 2.
//
// Decided for this implementation: the AHB-Lite register port and the address map.
`include "fdcs_cfg.svh"
module fdcs_status_core #(
  parameter int TICK_CYCLES = `FDCS_TICK_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // drive pins
  input wire logic drive_fault,
  input wire logic drive_wp,
  input wire logic drive_ready,
  input wire logic drive_track0,
  input wire logic drive_two_side,
  output logic [1:0] unit_select,
  output logic head_select,
  output logic head_load,
  output logic step_pulse,
  output logic step_dir,
  // read/write engine
  output logic engine_start,
  output logic [3:0] engine_op,
  output logic dma_select,
  input wire logic engine_done,
  input wire logic engine_abort,
  input wire logic [7:0] engine_id_err,
  input wire logic [7:0] engine_data_err,
  input wire logic engine_xfer_req,
  input wire logic [7:0] engine_rdata,
  output logic engine_xfer_ack,
  output logic [7:0] engine_wdata,
  // interrupt
  output logic irq
);

  fdcs_pkg::fdcs_core_t s;
  fdcs_pkg::fdcs_core_t n;
  logic [2:0] tdone;
  logic [2:0] tbusy;
  logic [8:0] tload [3];
  logic acc;
  logic cmd_wr;
  logic rdy_chg;
  logic rdy;
  logic [3:0] op_in;
  logic [7:0] id_err;

  ////////////////////////////////////////////////////////////////////////////
  // timers: 0 head unload, 1 step spacing, 2 head settle
  // unload count
  assign tload[0] = 9'(s.unload_code * `FDCS_UNLOAD_MS);
  assign tload[1] = 9'(`FDCS_STEP_MAX_MS - s.step_code);
  assign tload[2] = 9'(s.settle_code * `FDCS_SETTLE_MS);

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_tmr
      fdcs_interval_timer #(.TICK_CYCLES(TICK_CYCLES)) u_tmr (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .start(s.tstart[gi]),
        .load_ms(tload[gi]),
        .slow(s.slow_clk),
        .busy(tbusy[gi]),
        .done(tdone[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // next state
  assign acc = hsel & htrans[1] & hready;
  assign cmd_wr = s.wr_q & (s.addr_q == `FDCS_A_CMD);
  assign rdy = s.drv_s2[`FDCS_P_READY];
  assign rdy_chg = rdy ^ s.rdy_q;
  assign op_in = hwdata[`FDCS_F_OP];
  // missing data mark also sets the missing mark bit
  assign id_err = {engine_id_err[7], 1'b0, engine_id_err[5:4], 1'b0, engine_id_err[2:1],
                   engine_id_err[0] | engine_data_err[0]};

  always_comb begin
    n = s;
    n.exec_go = 1'b0;
    n.tstart = 3'h0;
    n.xfer_ack = 1'b0;
    n.step_out = 1'b0;
    n.drv_s1 = {drive_fault, drive_wp, drive_ready, drive_track0, drive_two_side};
    n.drv_s2 = s.drv_s1;
    n.rdy_q = rdy;
    // bus address phase
    n.wr_q = acc & hwrite;
    n.addr_q = haddr[7:0];
    if (acc && !hwrite) begin
      case (haddr[7:0])
        `FDCS_A_MAIN: begin
          n.hrdata = {24'h00_0000, (s.st == fdcs_pkg::st_idle) || (s.st == fdcs_pkg::st_result),
                      s.st == fdcs_pkg::st_result, s.st == fdcs_pkg::st_exec,
                      s.st != fdcs_pkg::st_idle, s.head_loaded, s.pio_sel, s.seek_pend,
                      s.xfer_pend};
        end
        `FDCS_A_CTRL: n.hrdata = {31'h0000_0000, s.slow_clk};
        `FDCS_A_TERM: n.hrdata = {24'h00_0000, s.term};
        `FDCS_A_XERR: n.hrdata = {24'h00_0000, s.xerr};
        `FDCS_A_DERR: n.hrdata = {24'h00_0000, s.derr};
        `FDCS_A_DRV: n.hrdata = {24'h00_0000, s.drv};
        `FDCS_A_CYL: n.hrdata = {24'h00_0000, s.cyl};
        `FDCS_A_XFER: n.hrdata = {24'h00_0000, engine_rdata};
        default: n.hrdata = 32'h0000_0000;
      endcase
      // result read ends the result interrupt
      if (haddr[7:0] == `FDCS_A_TERM) begin
        n.irq_result = 1'b0;
      end
      if (haddr[7:0] == `FDCS_A_XFER) begin
        n.xfer_pend = 1'b0;
        n.xfer_ack = 1'b1;
      end
    end
    // bus data phase writes
    if (s.wr_q && (s.addr_q == `FDCS_A_CTRL)) begin
      n.slow_clk = hwdata[`FDCS_B_SLOW];
    end
    if (s.wr_q && (s.addr_q == `FDCS_A_XFER)) begin
      n.xfer_wdata = hwdata[7:0];
      n.xfer_pend = 1'b0;
      n.xfer_ack = 1'b1;
    end
    // transfer request, set wins over a bus clear, loses to result entry
    if (engine_xfer_req && (s.st == fdcs_pkg::st_exec)) begin
      n.xfer_pend = 1'b1;
    end
    if (rdy_chg) begin
      n.rdy_pend = 1'b1;
    end
    if (tdone[0] && ((s.st == fdcs_pkg::st_idle) || (s.st == fdcs_pkg::st_result))) begin
      n.head_loaded = 1'b0;
    end
    case (s.st)
      fdcs_pkg::st_idle, fdcs_pkg::st_result: begin
        if (cmd_wr) begin
          n.op = op_in;
          n.unit = hwdata[`FDCS_F_UNIT];
          n.head = hwdata[`FDCS_B_HEAD];
          n.target = hwdata[`FDCS_F_ARG];
          n.st = fdcs_pkg::st_result;
          if (s.seek_pend && (op_in != `FDCS_OP_SENSE_INT)) begin
            n.term = `FDCS_TERM_INVALID;
          end else begin
            case (op_in)
              `FDCS_OP_SPECIFY: begin
                n.unload_code = hwdata[`FDCS_F_UNLOAD];
                n.step_code = hwdata[`FDCS_F_STEP];
                n.settle_code = hwdata[`FDCS_F_SETTLE];
                n.pio_sel = hwdata[`FDCS_B_PIO];
                n.st = fdcs_pkg::st_idle;
              end
              `FDCS_OP_SENSE_DRV: begin
                n.drv = {s.drv_s2, hwdata[`FDCS_B_HEAD], hwdata[`FDCS_F_UNIT]};
              end
              `FDCS_OP_SENSE_INT: begin
                // sense clears interrupt and reports cause
                n.irq_result = 1'b0;
                if (s.seek_pend) begin
                  n.term = s.seek_term;
                  n.seek_pend = 1'b0;
                end else if (s.rdy_pend && !rdy_chg) begin
                  n.term = {`FDCS_IC_READY, 6'h00};
                  n.rdy_pend = 1'b0;
                end else begin
                  n.term = `FDCS_TERM_INVALID;
                end
              end
              `FDCS_OP_SEEK, `FDCS_OP_RECAL: begin
                n.steps = 7'h00;
                if (op_in == `FDCS_OP_RECAL) begin
                  n.cyl = 8'h00;
                end
                n.st = fdcs_pkg::st_pos_step;
              end
              `FDCS_OP_READ, `FDCS_OP_WRITE, `FDCS_OP_SCAN, `FDCS_OP_FORMAT: begin
                n.xerr = 8'h00;
                n.derr = 8'h00;
                n.term = {`FDCS_IC_ABNORMAL, 3'h0, hwdata[`FDCS_B_HEAD], hwdata[`FDCS_F_UNIT]};
                if (!rdy || (hwdata[`FDCS_B_HEAD] && !s.drv_s2[`FDCS_P_TWOSIDE])) begin
                  n.term[3] = 1'b1;
                  n.irq_result = 1'b1;
                end else if (s.drv_s2[`FDCS_P_WP] &&
                             ((op_in == `FDCS_OP_WRITE) || (op_in == `FDCS_OP_FORMAT))) begin
                  n.xerr[1] = 1'b1;
                  n.irq_result = 1'b1;
                end else if (s.head_loaded) begin
                  // unload expiring in this cycle must not drop the head
                  n.head_loaded = 1'b1;
                  n.exec_go = 1'b1;
                  n.st = fdcs_pkg::st_exec;
                end else begin
                  n.head_loaded = 1'b1;
                  n.tstart[2] = 1'b1;
                  n.st = fdcs_pkg::st_settle;
                end
              end
              default: begin
                n.term = `FDCS_TERM_INVALID;
              end
            endcase
          end
        end
      end
      fdcs_pkg::st_settle: begin
        if (tdone[2]) begin
          n.exec_go = 1'b1;
          n.st = fdcs_pkg::st_exec;
        end
      end
      fdcs_pkg::st_exec: begin
        if (rdy_chg) begin
          n.term = {`FDCS_IC_READY, 3'h0, s.head, s.unit};
          n.irq_result = 1'b1;
          n.tstart[0] = 1'b1;
          n.xfer_pend = 1'b0;
          n.st = fdcs_pkg::st_result;
        end else if (engine_done) begin
          n.xerr = id_err;
          // data-field byte, bit 7 held zero
          n.derr = {1'b0, engine_data_err[6:0]};
          n.term = {`FDCS_IC_NORMAL, 3'h0, s.head, s.unit};
          if (engine_abort || (id_err != 8'h00) ||
              (engine_data_err & 8'h73) != 8'h00) begin
            n.term[7:6] = `FDCS_IC_ABNORMAL;
          end
          if (s.drv_s2[`FDCS_P_FAULT]) begin
            n.term = {`FDCS_IC_ABNORMAL, 1'b0, 1'b1, 1'b0, s.head, s.unit};
          end
          n.irq_result = 1'b1;
          n.tstart[0] = 1'b1;
          n.xfer_pend = 1'b0;
          n.st = fdcs_pkg::st_result;
        end
      end
      fdcs_pkg::st_pos_step: begin
        n.seek_term = {`FDCS_IC_NORMAL, 1'b1, 2'h0, s.head, s.unit};
        if (!rdy) begin
          n.seek_term = {`FDCS_IC_ABNORMAL, 1'b1, 1'b0, 1'b1, s.head, s.unit};
          n.seek_pend = 1'b1;
          n.st = fdcs_pkg::st_idle;
        end else if ((s.op == `FDCS_OP_RECAL) ? s.drv_s2[`FDCS_P_TRK0] : (s.cyl == s.target)) begin
          // positioning end interrupt, seek end set
          n.seek_pend = 1'b1;
          n.st = fdcs_pkg::st_idle;
        end else if ((s.op == `FDCS_OP_RECAL) && (s.steps == `FDCS_RECAL_STEPS)) begin
          // no track zero after all steps
          n.seek_term = {`FDCS_IC_ABNORMAL, 1'b1, 1'b1, 1'b0, s.head, s.unit};
          n.seek_pend = 1'b1;
          n.st = fdcs_pkg::st_idle;
        end else begin
          n.step_dir = (s.op == `FDCS_OP_SEEK) && (s.cyl < s.target);
          if (s.op == `FDCS_OP_SEEK) begin
            n.cyl = (s.cyl < s.target) ? s.cyl + 8'h01 : s.cyl - 8'h01;
          end
          n.steps = s.steps + 7'h01;
          n.step_out = 1'b1;
          n.tstart[1] = 1'b1;
          n.st = fdcs_pkg::st_pos_wait;
        end
      end
      fdcs_pkg::st_pos_wait: begin
        if (tdone[1]) begin
          n.st = fdcs_pkg::st_pos_step;
        end
      end
      default: n.st = fdcs_pkg::st_idle;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s.hrdata;
  assign unit_select = s.unit;
  assign head_select = s.head;
  assign head_load = s.head_loaded;
  assign step_pulse = s.step_out;
  assign step_dir = s.step_dir;
  assign engine_start = s.exec_go;
  assign engine_op = s.op;
  assign dma_select = ~s.pio_sel;
  assign engine_xfer_ack = s.xfer_ack;
  assign engine_wdata = s.xfer_wdata;
  assign irq = s.irq_result | s.seek_pend | s.rdy_pend | (s.pio_sel & s.xfer_pend);

endmodule // fdcs_status_core

// File: core/fdcs_cfg.svh
// Purpose: constants of the floppy status and interrupt core
// Assumes: one 40 MHz clock, AHB-Lite register window
// Notes: offsets are byte addresses of aligned words
`ifndef FDCS_CFG_SVH
`define FDCS_CFG_SVH
////////////////////////////////////////////////////////////////////////////////
// register offsets
`define FDCS_A_CMD 8'h00
`define FDCS_A_MAIN 8'h04
`define FDCS_A_CTRL 8'h08
`define FDCS_A_TERM 8'h0C
`define FDCS_A_XERR 8'h10
`define FDCS_A_DERR 8'h14
`define FDCS_A_DRV 8'h18
`define FDCS_A_CYL 8'h1C
`define FDCS_A_XFER 8'h20
////////////////////////////////////////////////////////////////////////////////
// command word fields, and the control register slow bit
`define FDCS_F_OP 3:0
`define FDCS_F_UNIT 5:4
`define FDCS_B_HEAD 6
`define FDCS_F_ARG 15:8
`define FDCS_F_UNLOAD 11:8
`define FDCS_F_STEP 15:12
`define FDCS_F_SETTLE 23:16
`define FDCS_B_PIO 24
`define FDCS_B_SLOW 0
////////////////////////////////////////////////////////////////////////////////
// command codes
`define FDCS_OP_SPECIFY 4'h1
`define FDCS_OP_SENSE_DRV 4'h2
`define FDCS_OP_SENSE_INT 4'h3
`define FDCS_OP_SEEK 4'h4
`define FDCS_OP_RECAL 4'h5
`define FDCS_OP_READ 4'h6
`define FDCS_OP_WRITE 4'h7
`define FDCS_OP_SCAN 4'h8
`define FDCS_OP_FORMAT 4'h9
////////////////////////////////////////////////////////////////////////////////
// drive pin vector positions
`define FDCS_P_FAULT 4
`define FDCS_P_WP 3
`define FDCS_P_READY 2
`define FDCS_P_TRK0 1
`define FDCS_P_TWOSIDE 0
////////////////////////////////////////////////////////////////////////////////
// termination codes and fixed values
`define FDCS_IC_NORMAL 2'h0
`define FDCS_IC_ABNORMAL 2'h1
`define FDCS_IC_INVALID 2'h2
`define FDCS_IC_READY 2'h3
`define FDCS_TERM_INVALID 8'h80
`define FDCS_RECAL_STEPS 7'h4D
////////////////////////////////////////////////////////////////////////////////
// timing, figures at the nominal 8 MHz rate
`define FDCS_CLK_NS 25
`define FDCS_MS_NS 1000000
`define FDCS_UNLOAD_MS 16
`define FDCS_STEP_MAX_MS 16
`define FDCS_SETTLE_MS 2
`define FDCS_TICK_CYCLES (`FDCS_MS_NS / `FDCS_CLK_NS)
`endif

// File: core/fdcs_pkg.sv
// Purpose: types of the floppy status and interrupt core
// Assumes: constants come from fdcs_cfg.svh
// Notes: state of each module is one packed struct
package fdcs_pkg;

  typedef enum logic [2:0] {
    st_idle,
    st_settle,
    st_exec,
    st_pos_step,
    st_pos_wait,
    st_result
  } fdcs_state_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic [8:0] ms_left;
    logic [17:0] pre;
  } fdcs_tmr_t;

  typedef struct packed {
    fdcs_state_t st;
    logic wr_q;
    logic [7:0] addr_q;
    logic [31:0] hrdata;
    logic [4:0] drv_s1;
    logic [4:0] drv_s2;
    logic rdy_q;
    logic [3:0] op;
    logic [1:0] unit;
    logic head;
    logic [7:0] target;
    logic [3:0] unload_code;
    logic [3:0] step_code;
    logic [7:0] settle_code;
    logic pio_sel;
    logic slow_clk;
    logic [7:0] term;
    logic [7:0] xerr;
    logic [7:0] derr;
    logic [7:0] drv;
    logic [7:0] cyl;
    logic [6:0] steps;
    logic head_loaded;
    logic step_dir;
    logic step_out;
    logic irq_result;
    logic seek_pend;
    logic rdy_pend;
    logic [7:0] seek_term;
    logic xfer_pend;
    logic xfer_ack;
    logic [7:0] xfer_wdata;
    logic exec_go;
    logic [2:0] tstart;
  } fdcs_core_t;

endpackage

// File: core/fdcs_interval_timer.sv
// Purpose: millisecond interval timer, loaded with a count of milliseconds
// Assumes: TICK_CYCLES clocks make one millisecond of the 8 MHz reference
// Notes: slow doubles every millisecond (4 MHz reference); load of zero ends at once
`include "fdcs_cfg.svh"
module fdcs_interval_timer #(
  parameter int TICK_CYCLES = `FDCS_TICK_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // control
  input wire logic start,
  input wire logic [8:0] load_ms,
  input wire logic slow,
  // status
  output logic busy,
  output logic done
);

  fdcs_pkg::fdcs_tmr_t s;
  fdcs_pkg::fdcs_tmr_t n;
  logic [17:0] limit;

  assign limit = slow ? 18'(2 * TICK_CYCLES - 1) : 18'(TICK_CYCLES - 1);

  always_comb begin
    n = s;
    n.done = 1'b0;
    if (start) begin
      n.busy = 1'b1;
      n.ms_left = load_ms;
      n.pre = 18'h0_0000;
    end else if (s.busy) begin
      if (s.ms_left == 9'h000) begin
        n.busy = 1'b0;
        n.done = 1'b1;
      end else if (s.pre == limit) begin
        n.pre = 18'h0_0000;
        n.ms_left = s.ms_left - 9'h001;
      end else begin
        n.pre = s.pre + 18'h0_0001;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign busy = s.busy;
  assign done = s.done;

endmodule // fdcs_interval_timer

// File: dv/fdcs_monitor.sv
// Purpose: port assertions of the status core
// Assumes: one clock, bound into every core
// Notes: command data phase decoded locally
module fdcs_monitor #(
  parameter int TICK_CYCLES = 40000
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  // drive, engine and interrupt
  input wire logic drive_ready,
  input wire logic step_pulse,
  input wire logic head_load,
  input wire logic engine_start,
  input wire logic engine_done,
  input wire logic engine_xfer_req,
  input wire logic dma_select,
  input wire logic irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic cmd_dp;
  logic spec_q;
  logic pio_q;
  logic gap_ok;
  logic [31:0] gap;
  ////////////////////////////////////////////////////////////////////////////
  // command data phase, cycles since last step
  always_ff @(posedge clk_sys) begin
    cmd_dp <= rstn && hsel && htrans[1] && hready && hwrite && haddr[7:0] == 8'h00;
    spec_q <= rstn && cmd_dp && hwdata[3:0] == 4'h1;
    pio_q <= hwdata[24];
    gap <= step_pulse ? 32'h0000_0001 : gap + 32'h0000_0001;
    gap_ok <= rstn && !irq && (step_pulse || gap_ok);
  end
  ////////////////////////////////////////////////////////////////////////////
  a_ready_irq:
  assert property ($changed(drive_ready) |-> ##[1:6] irq) else $error("no irq on ready change");
  a_done_irq:
  assert property (engine_done |-> ##[1:3] irq) else $error("no irq at result");
  a_pio_irq:
  assert property (engine_xfer_req && !dma_select |-> ##[1:3] irq) else $error("no byte irq");
  a_sense_clear:
  assert property (cmd_dp && hwdata[3:0] == 4'h3 |-> ##[1:3] !irq) else $error("irq not cleared");
  a_invalid_quiet:
  assert property (cmd_dp && hwdata[3:0] > 4'h9 && !irq |=> !irq [*4])
    else $error("irq on invalid command");
  a_mode_bit:
  assert property ($changed(dma_select) |-> spec_q && dma_select == !pio_q)
    else $error("transfer mode wrong");
  a_settle_load:
  assert property (engine_start |-> head_load) else $error("start with head unloaded");
  a_step_width:
  assert property (step_pulse |=> !step_pulse) else $error("step pulse too long");
  a_step_gap:
  assert property (step_pulse && gap_ok |-> gap >= TICK_CYCLES - 1) else $error("steps too close");
endmodule // fdcs_monitor

bind fdcs_status_core fdcs_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (.clk_sys, .rstn, .hsel,
  .haddr, .htrans, .hwrite, .hready, .hwdata, .drive_ready, .step_pulse, .head_load,
  .engine_start, .engine_done, .engine_xfer_req, .dma_select, .irq);

// File: dv/fdcs_drive_model.sv
// Purpose: head position and read/write engine of the far side
// Assumes: engine wants one byte, ends after the acknowledge
// Notes: result lines are inverted while not valid
module fdcs_drive_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // from the core
  input wire logic engine_start,
  input wire logic engine_xfer_ack,
  input wire logic step_pulse,
  input wire logic step_dir,
  // scenario settings
  input wire logic trk0_broken,
  input wire logic abort_set,
  input wire logic [7:0] id_set,
  input wire logic [7:0] data_set,
  // to the core
  output logic engine_done,
  output logic engine_abort,
  output logic [7:0] engine_id_err,
  output logic [7:0] engine_data_err,
  output logic engine_xfer_req,
  output logic [7:0] engine_rdata,
  output logic drive_track0
);
  int pos;
  int wait_n;
  logic [1:0] ph;
  assign engine_abort = engine_done ? abort_set : !abort_set;
  assign engine_id_err = engine_done ? id_set : ~id_set;
  assign engine_data_err = engine_done ? data_set : ~data_set;
  assign engine_rdata = ph == 2'd2 ? 8'h5A : 8'hA5;
  assign drive_track0 = pos == 0 && !trk0_broken;
  // phases: request delay, wait acknowledge, end delay
  always @(posedge clk_sys) begin
    engine_done <= 1'b0;
    engine_xfer_req <= 1'b0;
    if (!rstn) begin
      pos <= 0;
      ph <= 2'd0;
    end else begin
      if (step_pulse) begin
        pos <= step_dir ? pos + 1 : pos - 1;
      end
      if (engine_start) begin
        ph <= 2'd1;
        wait_n <= 3;
      end else if (ph == 2'd1 || ph == 2'd3) begin
        wait_n <= wait_n - 1;
        if (wait_n == 1) begin
          engine_xfer_req <= ph == 2'd1;
          engine_done <= ph == 2'd3;
          ph <= ph == 2'd1 ? 2'd2 : 2'd0;
        end
      end else if (ph == 2'd2 && engine_xfer_ack) begin
        ph <= 2'd3;
        wait_n <= 2;
      end
    end
  end
endmodule // fdcs_drive_model

// File: dv/tb_top.sv
// Purpose: self-checking bench of the status core
// Assumes: millisecond shortened to 8 clocks
// Notes: engine and head position from fdcs_drive_model
`include "fdcs_cfg.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TK = 8;
  logic clk_sys, rstn, hsel, hwrite, hready, hresp, head_select, head_load, step_pulse;
  logic step_dir, drive_fault, drive_wp, drive_ready, drive_track0, drive_two_side;
  logic engine_start, dma_select, engine_done, engine_abort, engine_xfer_req, engine_xfer_ack;
  logic irq, trk0_broken, abort_set;
  logic [1:0] htrans, unit_select;
  logic [2:0] hsize;
  logic [3:0] engine_op;
  logic [7:0] engine_id_err, engine_data_err, engine_rdata, engine_wdata, id_set, data_set;
  logic [31:0] haddr, hwdata, hrdata, rv;
  int num_errors, checked, sc, gap, nstep, hln, settle, n;
  fdcs_status_core #(.TICK_CYCLES(TK)) uut (.clk_sys, .rstn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hreadyout(hready), .hresp, .hrdata, .drive_fault,
    .drive_wp, .drive_ready, .drive_track0, .drive_two_side, .unit_select, .head_select,
    .head_load, .step_pulse, .step_dir, .engine_start, .engine_op, .dma_select, .engine_done,
    .engine_abort, .engine_id_err, .engine_data_err, .engine_xfer_req, .engine_rdata,
    .engine_xfer_ack, .engine_wdata, .irq);
  fdcs_drive_model u_far (.clk_sys, .rstn, .engine_start, .engine_xfer_ack, .step_pulse,
    .step_dir, .trk0_broken, .abort_set, .id_set, .data_set, .engine_done, .engine_abort,
    .engine_id_err, .engine_data_err, .engine_xfer_req, .engine_rdata, .drive_track0);
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // step spacing, step count, head settle length
  always @(posedge clk_sys) begin
    sc <= step_pulse ? 1 : sc + 1;
    gap <= step_pulse ? sc : gap;
    nstep <= nstep + int'(step_pulse);
    hln <= head_load ? hln + 1 : 0;
    settle <= engine_start ? hln : settle;
  end
  ////////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h00_0000, a};
    @(posedge clk_sys);
    while (hready !== 1'b1) @(posedge clk_sys);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clk_sys);
    while (hready !== 1'b1) @(posedge clk_sys);
    rv = hrdata;
  endtask
  task rd8(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 32'h0000_0000);
    check({24'h00_0000, rv[7:0]}, {24'h00_0000, e});
  endtask
  task cmd(input logic [3:0] op, input logic [1:0] u, input logic h, input logic [7:0] g);
    bus(1'b1, `FDCS_A_CMD, {16'h0000, g, 1'b0, h, u, op});
  endtask
  task spec(input logic pio, input logic [7:0] settle_code, input logic [3:0] step);
    bus(1'b1, `FDCS_A_CMD, {7'h00, pio, settle_code, step, 4'h1, 8'h01});
    @(posedge clk_sys);
  endtask
  task wirq(input int lim);
    for (int i = 0; i < lim && irq !== 1'b1; i++) @(posedge clk_sys);
    check(irq, 1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_ready();
    @(posedge clk_sys);
    drive_ready <= 1'b1;
    wirq(20);
    cmd(4'h3, 2'd0, 1'b0, 8'h00);
    rd8(`FDCS_A_TERM, 8'hC0);
    check(irq, 0);
  endtask
  task t_drive();
    @(posedge clk_sys);
    drive_fault <= 1'b1;
    cmd(4'h2, 2'd2, 1'b1, 8'h00);
    rd8(`FDCS_A_DRV, 8'hB6);
    drive_fault <= 1'b0;
    cmd(4'hF, 2'd0, 1'b0, 8'h00);
    bus(1'b0, `FDCS_A_MAIN, 32'h0000_0000);
    check(rv[7:6], 2'b11);
    rd8(`FDCS_A_TERM, 8'h80);
    check(irq, 0);
  endtask
  task t_seek();
    spec(1'b0, 8'h00, 4'hE);
    n = nstep;
    cmd(4'h4, 2'd1, 1'b0, 8'h03);
    wirq(300);
    check(nstep - n, 3);
    check(gap, 2 * TK + 4);
    check(step_dir, 1);
    cmd(4'h6, 2'd0, 1'b0, 8'h00);
    rd8(`FDCS_A_TERM, 8'h80);
    cmd(4'h3, 2'd0, 1'b0, 8'h00);
    rd8(`FDCS_A_TERM, 8'h21);
    rd8(`FDCS_A_CYL, 8'h03);
    check(irq, 0);
  endtask
  task t_recal();
    bus(1'b1, `FDCS_A_CTRL, 32'h0000_0001);
    trk0_broken <= 1'b1;
    spec(1'b0, 8'h00, 4'hF);
    n = nstep;
    cmd(4'h5, 2'd1, 1'b0, 8'h00);
    wirq(3000);
    check(nstep - n, 77);
    check(gap, 2 * TK + 4);
    cmd(4'h3, 2'd0, 1'b0, 8'h00);
    rd8(`FDCS_A_TERM, 8'h71);
    bus(1'b1, `FDCS_A_CTRL, 32'h0000_0000);
    trk0_broken <= 1'b0;
  endtask
  task t_rw();
    @(posedge clk_sys);
    drive_two_side <= 1'b1;
    abort_set <= 1'b1;
    id_set <= 8'hFF;
    data_set <= 8'hFF;
    spec(1'b1, 8'h02, 4'hF);
    check(dma_select, 0);
    cmd(4'h6, 2'd0, 1'b1, 8'h00);
    wirq(200);
    rd8(`FDCS_A_XFER, 8'h5A);
    repeat (2) @(posedge clk_sys);
    wirq(50);
    check(settle, 4 * TK + 3);
    rd8(`FDCS_A_TERM, 8'h44);
    rd8(`FDCS_A_XERR, 8'hB7);
    rd8(`FDCS_A_DERR, 8'h7F);
    check(irq, 0);
    abort_set <= 1'b0;
    id_set <= 8'h00;
    data_set <= 8'h01;
    spec(1'b0, 8'h02, 4'hF);
    check(dma_select, 1);
    cmd(4'h6, 2'd3, 1'b0, 8'h00);
    repeat (10) @(posedge clk_sys);
    bus(1'b0, `FDCS_A_XFER, 32'h0000_0000);
    wirq(50);
    rd8(`FDCS_A_TERM, 8'h43);
    rd8(`FDCS_A_XERR, 8'h01);
  endtask
  task t_nr();
    drive_two_side <= 1'b0;
    cmd(4'h7, 2'd0, 1'b1, 8'h00);
    wirq(20);
    rd8(`FDCS_A_TERM, 8'h4C);
    drive_two_side <= 1'b1;
    drive_wp <= 1'b1;
    cmd(4'h9, 2'd0, 1'b0, 8'h00);
    wirq(20);
    rd8(`FDCS_A_TERM, 8'h40);
    rd8(`FDCS_A_XERR, 8'h02);
  endtask
  task report_and_stop();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rstn, hsel, hwrite, drive_fault, drive_wp, drive_ready, drive_two_side} = '0;
    {trk0_broken, abort_set, htrans, id_set, data_set, haddr, hwdata} = '0;
    hsize = 3'b010;
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    t_ready();
    t_drive();
    t_seek();
    t_recal();
    t_rw();
    t_nr();
    report_and_stop();
  end
  initial begin
    repeat (8000) @(posedge clk_sys);
    num_errors++;
    report_and_stop();
  end
endmodule // tb_top
